//--- dv/sample_queue_control_tb.sv
/*
 Bench: register accesses, sample pushes and stream drains.
 Assumes design, package, checker and reader compiled first.
*/
`default_nettype none
module sample_queue_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   sqc_pkg::sqc_reg_req_t regReq = '0;
   logic [7:0] regRdData;
   logic [47:0] sampleData = '0;
   logic sampleStrobe = 1'b0;
   logic [47:0] outData;
   logic outValid;
   logic outReady;
   logic motionIrq = 1'b0;
   logic sampleIrq = 1'b0;
   logic irqPinAN;
   logic irqPinBN;
   sqc_pkg::sqc_flags_t pendingFlags;
   logic stall = 1'b1;
   int nMismatch = 0;
   int totalChecks = 0;
   int cyc = 0;
   always #20 clk_sys = ~clk_sys;
   sample_queue_control u_sample_queue_control (.clk_sys(clk_sys), .rst_n(rst_n),
      .regReq(regReq), .regRdData(regRdData), .sampleData(sampleData),
      .sampleStrobe(sampleStrobe), .outData(outData), .outValid(outValid),
      .outReady(outReady), .motionIrq(motionIrq), .sampleIrq(sampleIrq),
      .irqPinAN(irqPinAN), .irqPinBN(irqPinBN), .pendingFlags(pendingFlags));
   sqc_reader u_sqc_reader (.clk_sys(clk_sys), .stall(stall), .outValid(outValid),
      .outData(outData), .outReady(outReady));
   task automatic closeOut();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : closeOut
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("wrong value at %0t: byte %h not %h", $time, got, exp);
      end
   endtask : chkByte
   task automatic chkWord(input logic [47:0] got, input logic [47:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("wrong value at %0t: word %h not %h", $time, got, exp);
      end
   endtask : chkWord
   // Idle cycle after each access keeps strobes one per time step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regReq <= '{1'b1, 1'b0, a, d};
      @(negedge clk_sys);
      regReq <= '0;
      @(negedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regReq <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_sys);
      regReq <= '0;
      chkByte(regRdData, exp);
      @(negedge clk_sys);
   endtask : rd
   task automatic push(input int n, input logic [47:0] base);
      for (int i = 0; i < n; i++)
      begin
         sampleData <= base + 48'(i);
         sampleStrobe <= 1'b1;
         @(negedge clk_sys);
      end
      sampleStrobe <= 1'b0;
      @(negedge clk_sys);
   endtask : push
   task automatic drain(input int n, input logic [47:0] base);
      stall <= 1'b0;
      repeat (40) @(negedge clk_sys);
      stall <= 1'b1;
      @(negedge clk_sys);
      chkByte(8'(u_sqc_reader.got.size()), 8'(n));
      for (int i = 0; i < n && i < u_sqc_reader.got.size(); i++)
      begin
         chkWord(u_sqc_reader.got[i], base + 48'(i));
      end
      u_sqc_reader.got.delete();
   endtask : drain
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         nMismatch++;
         closeOut();
      end
   end
   initial
   begin
      repeat (2) @(negedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h03);
      sampleIrq <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h01);
      sampleIrq <= 1'b0;
      rd(8'h2D, 8'h00);
      rd(8'h2E, 8'h10);
      rd(8'h2F, 8'h00);
      rd(8'h30, 8'h00);
      wr(8'h2E, 8'hFF);
      rd(8'h2E, 8'h1F);
      wr(8'h2D, 8'h07);
      push(1, 48'h0);
      rd(8'h2F, 8'h00);
      wr(8'h2D, 8'h27);
      rd(8'h2D, 8'h27);
      rd(8'h2F, 8'h01);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h02);
      motionIrq <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h00);
      motionIrq <= 1'b0;
      push(33, 48'h100);
      rd(8'h2F, 8'h06);
      chkByte({5'h00, pendingFlags}, 8'h06);
      drain(32, 48'h100);
      rd(8'h2F, 8'h01);
      wr(8'h2E, 8'h03);
      wr(8'h2D, 8'h67);
      push(5, 48'h200);
      rd(8'h2F, 8'h04);
      drain(3, 48'h200);
      push(2, 48'h300);
      wr(8'h2D, 8'h37);
      rd(8'h2F, 8'h01);
      drain(0, 48'h0);
      wr(8'h2D, 8'h2F);
      repeat (2) @(negedge clk_sys);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h01);
      wr(8'h2D, 8'h08);
      sampleIrq <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h01);
      sampleIrq <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n <= 1'b1;
      rd(8'h2D, 8'h00);
      rd(8'h2E, 8'h10);
      chkByte({6'h00, irqPinAN, irqPinBN}, 8'h03);
      wr(8'h2D, 8'h00);
      rd(8'h2F, 8'h00);
      closeOut();
   end
endmodule : sample_queue_control_tb
`default_nettype wire

//--- dv/sqc_properties.sv
/*
 Port checker of the sample queue block.
 Assumes the bind below attaches it to every instance.
*/
`default_nettype none
module sqc_properties #(
   parameter int SAMPLE_W = 48
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire sqc_pkg::sqc_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   input wire logic [SAMPLE_W-1:0] outData,
   input wire logic outValid,
   input wire logic outReady,
   input wire logic motionIrq,
   input wire logic sampleIrq,
   input wire logic irqPinAN,
   input wire logic irqPinBN,
   input wire sqc_pkg::sqc_flags_t pendingFlags
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_rd(a);
      regReq.rdEn && regReq.addr == a;
   endsequence
   property p_ctl;
      s_rd(8'h2D) |=> regRdData[7] == 1'b0 && regRdData[4] == 1'b0;
   endproperty
   a_ctl: assert property (p_ctl) else $error("control bit 7 or 4 read set");
   property p_wmk;
      s_rd(8'h2E) |=> regRdData[7:5] == 3'h0;
   endproperty
   a_wmk: assert property (p_wmk) else $error("watermark top bits set");
   property p_flg;
      s_rd(8'h2F) |=> regRdData == {5'h00, $past(pendingFlags)};
   endproperty
   a_flg: assert property (p_flg) else $error("flag read wrong");
   property p_exc;
      !(pendingFlags.full && pendingFlags.empty);
   endproperty
   a_exc: assert property (p_exc) else $error("full and empty together");
   property p_pinB;
      !irqPinBN |-> $past(|pendingFlags);
   endproperty
   a_pinB: assert property (p_pinB) else $error("pin B low without flag");
   property p_pinA;
      !irqPinAN |-> $past(motionIrq || sampleIrq || (|pendingFlags));
   endproperty
   a_pinA: assert property (p_pinA) else $error("pin A low without cause");
   property p_flagPin;
      |pendingFlags |=> !irqPinAN || !irqPinBN;
   endproperty
   a_flagPin: assert property (p_flagPin) else $error("flag not on a pin");
   property p_motion;
      motionIrq |=> !irqPinAN;
   endproperty
   a_motion: assert property (p_motion) else $error("motion not on pin A");
   property p_stall;
      outValid && !outReady && !regReq.wrEn |=> outValid && $stable(outData);
   endproperty
   a_stall: assert property (p_stall) else $error("stalled word lost");
   property p_empty;
      pendingFlags.empty |-> !outValid;
   endproperty
   a_empty: assert property (p_empty) else $error("empty with word out");
endmodule : sqc_properties

bind sample_queue_control sqc_properties #(.SAMPLE_W(SAMPLE_W)) u_sqc_properties (
   .clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
   .outData(outData), .outValid(outValid), .outReady(outReady),
   .motionIrq(motionIrq), .sampleIrq(sampleIrq), .irqPinAN(irqPinAN),
   .irqPinBN(irqPinBN), .pendingFlags(pendingFlags));
`default_nettype wire

//--- dv/sqc_reader.sv
/*
 Reader at the output stream: stalls on command, logs popped words.
 Assumes stall changes off the rising edge.
*/
`default_nettype none
module sqc_reader #(
   parameter int SAMPLE_W = 48
) (
   input wire logic clk_sys,
   input wire logic stall,
   input wire logic outValid,
   input wire logic [SAMPLE_W-1:0] outData,
   output logic outReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SAMPLE_W-1:0] got [$];
   // Slow reader holds ready low for as long as told
   assign outReady = !stall;
   always @(posedge clk_sys)
   begin
      if (outValid && outReady)
      begin
         got.push_back(outData);
      end
   end
endmodule : sqc_reader
`default_nettype wire

//--- hdl/sample_queue_control.sv
/*
 Sample queue with control, watermark and interrupt status logic, plus a
 two-entry output buffer so that a stalled reader loses no word.
 Assumes register accesses arrive already decoded from the serial interface,
 one access per cycle, and that sampleStrobe pulses once per output data rate
 sample, after any decimation.
*/
// Notes on behaviour
// R1: Queue works only while enable bit set
// R2: Normal mode stores while space remains
// R3: Watermark mode drops samples at or above level
// R4: Queue reset clears pointers, keeps contents
// R5: Separate mode: motion on A, queue on B
// R6: Combined mode: everything on A, B idle
// R7: Control bit 0 enables empty interrupt
// R8: Control bit 1 enables full interrupt
// R9: Control bit 2 enables threshold interrupt
// R10: Host writes zero to control bit 7
// R11: Control register resets to 0x00
// R12: Watermark level five bits, resets to 16
// R13: Host programs watermark between 1 and 31
// R14: Watermark bits 7:5 read zero
// R15: Flags reported only when enabled
// R16: Flag bit 0 shows empty pending
// R17: Flag bit 1 shows full pending
// R18: Flag bit 2 shows threshold pending
// R19: Flag bits 7:3 read zero
// R20: Queue written at output data rate
// R21: Empty at zero, full at 32, threshold at level
// R22: Pending flags are levels driving active-low pins
`include "sqc_cfg.svh"
`default_nettype none

module sample_queue_control #(
   parameter int DEPTH = `SQC_DEPTH,
   parameter int SAMPLE_W = `SQC_SAMPLE_W
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire sqc_pkg::sqc_reg_req_t regReq,
   output logic [7:0] regRdData,
   input wire logic [SAMPLE_W-1:0] sampleData,
   input wire logic sampleStrobe,
   output logic [SAMPLE_W-1:0] outData,
   output logic outValid,
   input wire logic outReady,
   input wire logic motionIrq,
   input wire logic sampleIrq,
   output logic irqPinAN,
   output logic irqPinBN,
   output sqc_pkg::sqc_flags_t pendingFlags
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = PTR_W + 2;
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
   localparam logic [1:0] BUF_MAX = 2'(`SQC_BUF_DEPTH);
   // Reset pattern as a constant, so that its fields can be selected
   localparam logic [7:0] CTL_RST = `SQC_CONTROL_RST;

   // Control and watermark register fields
   logic emptyIe;
   logic fullIe;
   logic threshIe;
   logic combineInterrupts;
   logic queueEnable;
   logic watermarkMode;
   logic [`SQC_LEVEL_W-1:0] queueWatermarkLevel;

   // Storage and pointers; pointers carry one extra bit to tell full from empty
   logic [SAMPLE_W-1:0] mem [DEPTH];
   logic [PTR_W:0] wrPtr;
   logic [PTR_W:0] rdPtr;

   // Two-entry output buffer
   logic [SAMPLE_W-1:0] buf0;
   logic [SAMPLE_W-1:0] buf1;
   logic [1:0] bufCount;

   logic queueReset;
   logic [CNT_W-1:0] memCount;
   logic [CNT_W-1:0] totalCount;
   logic accept;
   logic pull;
   logic pop;
   logic [1:0] next_bufCount;
   sqc_pkg::sqc_flags_t next_flags;
   logic queueAny;
   logic [7:0] next_rdData;

   function automatic logic regHit(input sqc_pkg::sqc_reg_req_t req, input logic [7:0] ofs);
      regHit = req.wrEn && (req.addr == ofs);
   endfunction : regHit

   function automatic logic [CNT_W-1:0] ptrDiff(input logic [PTR_W:0] a, input logic [PTR_W:0] b);
      logic [PTR_W:0] d;
      d = a - b;
      ptrDiff = CNT_W'(d);
   endfunction : ptrDiff

   // Writing 1 to the reset bit is a one-shot; the bit itself is not stored
   assign queueReset = regHit(regReq, `SQC_OFS_CONTROL) && regReq.wrData[`SQC_CTL_QRESET]; // R4

   // Bit 7 and the one-shot bit 4 have no storage
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         emptyIe <= CTL_RST[`SQC_CTL_EMPTY_IE]; // R11
         fullIe <= CTL_RST[`SQC_CTL_FULL_IE];
         threshIe <= CTL_RST[`SQC_CTL_THRESH_IE];
         combineInterrupts <= CTL_RST[`SQC_CTL_COMBINE];
         queueEnable <= CTL_RST[`SQC_CTL_ENABLE];
         watermarkMode <= CTL_RST[`SQC_CTL_MODE];
      end
      else if (regHit(regReq, `SQC_OFS_CONTROL))
      begin
         emptyIe <= regReq.wrData[`SQC_CTL_EMPTY_IE]; // R7
         fullIe <= regReq.wrData[`SQC_CTL_FULL_IE]; // R8
         threshIe <= regReq.wrData[`SQC_CTL_THRESH_IE]; // R9
         combineInterrupts <= regReq.wrData[`SQC_CTL_COMBINE];
         queueEnable <= regReq.wrData[`SQC_CTL_ENABLE];
         watermarkMode <= regReq.wrData[`SQC_CTL_MODE];
      end
   end

   // Level 0 is outside the legal range; it is stored as written, not corrected
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         queueWatermarkLevel <= `SQC_WATERMARK_RST; // R12
      end
      else if (regHit(regReq, `SQC_OFS_WATERMARK))
      begin
         queueWatermarkLevel <= regReq.wrData[`SQC_LEVEL_W-1:0]; // R12
      end
   end

   // Samples held in the output buffer still count as stored
   assign memCount = ptrDiff(wrPtr, rdPtr);
   assign totalCount = memCount + CNT_W'(bufCount);

   // A strobe that is not accepted is dropped; the sensor cannot be stalled
   always_comb
   begin
      accept = sampleStrobe && queueEnable && !queueReset; // R1 R20
      if (totalCount >= DEPTH_C)
      begin
         accept = 1'b0; // R2
      end
      if (watermarkMode && (totalCount >= CNT_W'(queueWatermarkLevel)))
      begin
         accept = 1'b0; // R3
      end
   end

   // Refill the buffer whenever it has room, even in the cycle it drains
   // Pops are ignored while disabled, so head data cannot shift under a frozen count
   assign pop = outValid && outReady && queueEnable; // R1
   assign pull = queueEnable && !queueReset && (memCount != '0)
      && ((bufCount < BUF_MAX) || pop); // R1

   always_comb
   begin
      next_bufCount = bufCount;
      if (pull && !pop)
      begin
         next_bufCount = bufCount + 2'd1;
      end
      else if (pop && !pull)
      begin
         next_bufCount = bufCount - 2'd1;
      end
   end

   // Contents are never cleared, not even by queue reset
   always_ff @(posedge clk_sys)
   begin
      if (accept)
      begin
         mem[wrPtr[PTR_W-1:0]] <= sampleData;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || queueReset)
      begin
         wrPtr <= '0; // R4
      end
      else if (accept)
      begin
         wrPtr <= wrPtr + 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || queueReset)
      begin
         rdPtr <= '0; // R4
      end
      else if (pull)
      begin
         rdPtr <= rdPtr + 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || queueReset)
      begin
         bufCount <= '0; // R4
         outValid <= 1'b0;
      end
      // Buffer freezes while the queue is disabled
      else if (queueEnable)
      begin
         bufCount <= next_bufCount;
         outValid <= (next_bufCount != 2'd0);
      end
   end

   // Data words shift toward the head; no reset needed on data
   always_ff @(posedge clk_sys)
   begin
      if (pop)
      begin
         buf0 <= buf1;
      end
      if (pull)
      begin
         if ((bufCount == 2'd0) || ((bufCount == 2'd1) && pop))
         begin
            buf0 <= mem[rdPtr[PTR_W-1:0]];
         end
         else
         begin
            buf1 <= mem[rdPtr[PTR_W-1:0]];
         end
      end
   end

   assign outData = buf0;

   // Flags are levels: they follow their condition, gated by the enables
   always_comb
   begin
      next_flags.empty = emptyIe && (totalCount == '0); // R15 R21
      next_flags.full = fullIe && (totalCount >= DEPTH_C); // R15 R21
      next_flags.thresh = threshIe && (totalCount >= CNT_W'(queueWatermarkLevel)); // R15 R21
      if (!queueEnable)
      begin
         next_flags = '0; // R1
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pendingFlags <= '0;
      end
      else
      begin
         pendingFlags <= next_flags; // R22
      end
   end

   // Any enabled flag asserts queue pin B, or pin A in combined mode
   assign queueAny = |pendingFlags;

   // Pins are active low and idle high
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         irqPinAN <= 1'b1;
         irqPinBN <= 1'b1;
      end
      // Combined mode keeps pin B released
      else if (combineInterrupts)
      begin
         irqPinAN <= !(motionIrq || sampleIrq || queueAny); // R6 R22
         irqPinBN <= 1'b1; // R6
      end
      else
      begin
         irqPinAN <= !(motionIrq || sampleIrq); // R5
         irqPinBN <= !queueAny; // R5 R22
      end
   end

   // Unmapped addresses read zero
   always_comb
   begin
      next_rdData = 8'h00;
      unique case (regReq.addr)
         `SQC_OFS_CONTROL:
         begin
            next_rdData[`SQC_CTL_EMPTY_IE] = emptyIe;
            next_rdData[`SQC_CTL_FULL_IE] = fullIe;
            next_rdData[`SQC_CTL_THRESH_IE] = threshIe;
            next_rdData[`SQC_CTL_COMBINE] = combineInterrupts;
            next_rdData[`SQC_CTL_ENABLE] = queueEnable;
            next_rdData[`SQC_CTL_MODE] = watermarkMode;
            // Bits 7 and 4 stay zero from the default above
         end
         `SQC_OFS_WATERMARK:
         begin
            next_rdData[`SQC_LEVEL_W-1:0] = queueWatermarkLevel; // R14
            next_rdData[7:`SQC_LEVEL_W] = 3'h0; // R14
         end
         `SQC_OFS_FLAGS:
         begin
            next_rdData[`SQC_FLG_EMPTY] = pendingFlags.empty; // R16 R19
            next_rdData[`SQC_FLG_FULL] = pendingFlags.full; // R17
            next_rdData[`SQC_FLG_THRESH] = pendingFlags.thresh; // R18
            next_rdData[7:3] = 5'h00; // R19
         end
         default:
         begin
            next_rdData = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         regRdData <= 8'h00;
      end
      // Holds the last read until the next read strobe
      else if (regReq.rdEn)
      begin
         regRdData <= next_rdData;
      end
   end

endmodule : sample_queue_control

`default_nettype wire

//--- hdl/sqc_cfg.svh
/*
 Register offsets, field positions, reset values and sizes of the sample queue control block.
 Assumes it is included by bare name from the package and the design module.
*/
`ifndef SQC_CFG_SVH
`define SQC_CFG_SVH

// Register offsets
`define SQC_OFS_CONTROL 8'h2D
`define SQC_OFS_WATERMARK 8'h2E
`define SQC_OFS_FLAGS 8'h2F

// Control register fields
`define SQC_CTL_EMPTY_IE 0
`define SQC_CTL_FULL_IE 1
`define SQC_CTL_THRESH_IE 2
`define SQC_CTL_COMBINE 3
`define SQC_CTL_QRESET 4
`define SQC_CTL_ENABLE 5
`define SQC_CTL_MODE 6

// Flag register fields
`define SQC_FLG_EMPTY 0
`define SQC_FLG_FULL 1
`define SQC_FLG_THRESH 2

// Reset values
`define SQC_CONTROL_RST 8'h00
`define SQC_WATERMARK_RST 5'h10

// Sizes
`define SQC_DEPTH 32
`define SQC_SAMPLE_W 48
`define SQC_LEVEL_W 5
`define SQC_BUF_DEPTH 2

`endif

//--- hdl/sqc_pkg.sv
/*
 Types shared by the sample queue control block and its bench.
 Assumes sqc_cfg.svh is on the include path.
*/
`include "sqc_cfg.svh"
`default_nettype none

package sqc_pkg;

   // One register access from the serial interface decoder
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } sqc_reg_req_t;

   // Pending queue conditions, already gated by their enables
   typedef struct packed {
      logic thresh;
      logic full;
      logic empty;
   } sqc_flags_t;

endpackage : sqc_pkg

`default_nettype wire
